// ==== nbmf_map.svh ====
// byte offsets, fixed field values and frame sizes of the boot message framer
// assumes offsets are counted in bytes; message offsets start at the subtype field
`ifndef NBMF_MAP_SVH
`define NBMF_MAP_SVH
// ************************************************************
// frame layout
// ************************************************************
`define NB_MAC_LEN 10'd6
`define NB_SRC_END 10'd12
`define NB_ETH_HDR 10'd14
`define NB_OFF_ID 10'd2
`define NB_OFF_SESS_END 10'd14
`define NB_OFF_REQ 10'd18
`define NB_OFF_RPL 10'd19
`define NB_OFF_LEN 10'd20
`define NB_OFF_VER 10'd22
`define NB_OFF_NBUF 10'd24
`define NB_OFF_BLEN 10'd26
`define NB_OFF_STN 10'd28
`define NB_OFF_SESS 10'd34
`define NB_OFF_TMO 10'd46
`define NB_OFF_CFG 10'd48
`define NB_TX_LAST 10'd141
`define NB_RX_SAT 10'h3FF
// ************************************************************
// fixed field values
// ************************************************************
`define NB_ETHTYPE 16'h7A3C // arbitrary stand-in for the fixed protocol type code
`define NB_SUBTYPE 16'h0000
`define NB_REQ_LEN 16'h006A
`define NB_RPL_LEN 16'h001A
`define NB_VERSION 16'h0001
`define NB_NBUF 16'h0001
`define NB_BUFLEN 16'h01FC
`define NB_CODE_FIND 8'h04
`define NB_CODE_SEL 8'h05
`define NB_CODE_CMD_MAX 8'h03
`define NB_BCAST 48'hFFFF_FFFF_FFFF
`endif

// ==== nbmf_pkg.sv ====
// types shared by the boot message framer
// assumes the map header supplies all numeric constants
package nbmf_pkg;
    // one byte of the outgoing frame with its end marker
    typedef struct packed {
        logic [7:0] data;
        logic last;
    } nbmf_beat_s;
    // client session progress
    typedef enum logic [3:0] {
        NBMF_IDLE = 4'h1,
        NBMF_FIND = 4'h2,
        NBMF_SEL = 4'h4,
        NBMF_OPEN = 4'h8
    } nbmf_sess_e;
    // frame generator
    typedef enum logic [1:0] {
        NBMF_TX_IDLE = 2'h1,
        NBMF_TX_RUN = 2'h2
    } nbmf_tx_e;
endpackage

// ==== nbmf_framer.sv ====
// boot request framer with reply and command checking
// assumes a same-clock MAC that adds preamble and FCS and sends bits LSB first
// How it works
// - each data byte goes out least significant bit first
// - multi-byte fields go out lowest address byte first
// - host byte-swap option never touches boot message contents
// - header: subtype 0, id 2, request 18, reply 19, length 20, body 22
// - subtype is zero in every request and reply
// - request code picks operation; reply reuses the request's code
// - requests carry reply code zero
// - length counts bytes after the length field, no FCS
// - discovery goes to broadcast, everything else to the server address
// - source address is the sender's own address
// - frame type is the fixed protocol code, left byte first
// - body offsets count from the subtype field
// - discovery, reply, selection, reply, in that order
// - each request has a unique id; replies echo it
// - discovery and selection carry reply code zero both ways
// - length 106 in requests, 26 in replies
// - body: version, buffers, length, station, session, timeout, config
// - protocol version is 1
// - buffer count is 1
// - buffer length is 508
// - commands whose id does not start with the session are discarded
`timescale 1ns/1ps
`include "nbmf_map.svh"
module nbmf_framer
    import nbmf_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [47:0] own_mac_i,
    input wire logic [127:0] msg_id_i,
    input wire logic [15:0] rx_timeout_i,
    input wire logic start_find_i,
    input wire logic start_select_i,
    input wire logic [7:0] cfg_byte_i,
    output logic [6:0] cfg_index_o,
    output logic tx_busy_o,
    output nbmf_beat_s tx_beat_o,
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_valid_i,
    input wire logic rx_last_i,
    output logic find_reply_o,
    output logic select_reply_o,
    output logic server_known_o,
    output logic session_open_o,
    output logic [47:0] server_addr_o,
    output logic [15:0] server_timeout_o,
    output logic rx_cmd_valid_o,
    output logic [7:0] rx_cmd_code_o,
    output logic [127:0] rx_cmd_id_o,
    output logic [15:0] rx_cmd_len_o
);
    // ************************************************************
    // helpers
    // ************************************************************
    // byte k of a field, byte 0 being the first on the wire
    function automatic logic [7:0] nbmf_pick(input logic [127:0] v, input logic [3:0] k);
        nbmf_pick = 8'(v >> {k, 3'b000});
    endfunction
    // little-endian byte of a 16-bit field, never swapped by host options
    function automatic logic [7:0] nbmf_le(input logic [15:0] v, input logic hi);
        nbmf_le = hi ? v[15:8] : v[7:0];
    endfunction
    // byte i of an outgoing discovery or selection request frame
    function automatic logic [7:0] nbmf_tx_byte(input logic [9:0] i, input logic find,
        input logic [47:0] srv, input logic [47:0] own, input logic [127:0] id,
        input logic [7:0] code, input logic [15:0] tmo, input logic [7:0] cfg);
        logic [9:0] m;
        m = i - `NB_ETH_HDR;
        if (i < `NB_MAC_LEN) nbmf_tx_byte = nbmf_pick({80'h0, find ? `NB_BCAST : srv}, i[3:0]);
        else if (i < `NB_SRC_END) nbmf_tx_byte = nbmf_pick({80'h0, own}, 4'(i - `NB_MAC_LEN));
        else if (i < `NB_ETH_HDR) nbmf_tx_byte = nbmf_le(`NB_ETHTYPE, i == `NB_SRC_END);
        else if (m < `NB_OFF_ID) nbmf_tx_byte = nbmf_le(`NB_SUBTYPE, m[0]);
        else if (m < `NB_OFF_REQ) nbmf_tx_byte = nbmf_pick(id, 4'(m - `NB_OFF_ID));
        else if (m == `NB_OFF_REQ) nbmf_tx_byte = code;
        else if (m == `NB_OFF_RPL) nbmf_tx_byte = 8'h00;
        else if (m < `NB_OFF_VER) nbmf_tx_byte = nbmf_le(`NB_REQ_LEN, m[0]);
        else if (m < `NB_OFF_NBUF) nbmf_tx_byte = nbmf_le(`NB_VERSION, m[0]);
        else if (m < `NB_OFF_BLEN) nbmf_tx_byte = nbmf_le(`NB_NBUF, m[0]);
        else if (m < `NB_OFF_STN) nbmf_tx_byte = nbmf_le(`NB_BUFLEN, m[0]);
        else if (m < `NB_OFF_SESS) nbmf_tx_byte = nbmf_pick({80'h0, own}, 4'(m - `NB_OFF_STN));
        else if (m < `NB_OFF_TMO) nbmf_tx_byte = 8'h00; // session id is undefined in requests
        else if (m < `NB_OFF_CFG) nbmf_tx_byte = nbmf_le(tmo, m[0]);
        else nbmf_tx_byte = cfg;
    endfunction
    // ************************************************************
    // state
    // ************************************************************
    nbmf_sess_e sess_st, next_sess_st;
    nbmf_tx_e tx_st, next_tx_st;
    logic [9:0] tx_idx, next_tx_idx, rx_idx, next_rx_idx;
    logic tx_find, next_tx_find, next_tx_busy, push, start_find_ok, start_sel_ok;
    logic [127:0] sent_id, next_sent_id, session, next_session, next_rx_cmd_id, cap_id, next_cap_id;
    logic [15:0] sent_tmo, next_sent_tmo, next_server_timeout, next_rx_cmd_len;
    logic [15:0] cap_len, next_cap_len, cap_tmo, next_cap_tmo;
    logic [6:0] next_cfg_index;
    logic next_server_known, next_find_reply, next_select_reply, next_rx_cmd_valid;
    logic [47:0] next_server_addr, cap_stn, next_cap_stn;
    logic [7:0] next_rx_cmd_code, cap_code, next_cap_code, cap_rpl, next_cap_rpl;
    logic drop, next_drop, src_mis, next_src_mis, id_mis, next_id_mis, sess_mis, next_sess_mis;
    logic [95:0] cap_sess, next_cap_sess;
    nbmf_beat_s skid, next_skid, next_tx_beat, push_beat;
    logic skid_v, next_skid_v, next_tx_valid;
    // a start is taken only while no frame is being generated; discovery wins
    assign start_find_ok = start_find_i && (tx_st == NBMF_TX_IDLE);
    assign start_sel_ok = start_select_i && !start_find_i && (tx_st == NBMF_TX_IDLE) && server_known_o;
    // ************************************************************
    // request generator
    // ************************************************************
    // walks the 142-byte frame once; config bytes are looked up by index
    always_comb begin
        next_tx_st = tx_st;
        next_tx_idx = tx_idx;
        next_tx_find = tx_find;
        next_sent_id = sent_id;
        next_sent_tmo = sent_tmo;
        push = 1'b0;
        push_beat.data = nbmf_tx_byte(tx_idx, tx_find, server_addr_o, own_mac_i, sent_id,
            tx_find ? `NB_CODE_FIND : `NB_CODE_SEL, sent_tmo, cfg_byte_i);
        push_beat.last = (tx_idx == `NB_TX_LAST);
        case (tx_st)
            NBMF_TX_IDLE: begin
                if (start_find_ok || start_sel_ok) begin
                    next_tx_st = NBMF_TX_RUN;
                    next_tx_idx = 10'h000;
                    next_tx_find = start_find_ok;
                    next_sent_id = msg_id_i;
                    next_sent_tmo = rx_timeout_i;
                end
            end
            NBMF_TX_RUN: begin
                push = !skid_v; // stall the walk while the buffer is full
                if (push) begin
                    next_tx_idx = tx_idx + 10'h001;
                    if (push_beat.last) begin
                        next_tx_st = NBMF_TX_IDLE;
                    end
                end
            end
            default: begin
                next_tx_st = NBMF_TX_IDLE;
            end
        endcase
        next_tx_busy = (next_tx_st == NBMF_TX_RUN);
        next_cfg_index = 7'(next_tx_idx - `NB_ETH_HDR - `NB_OFF_CFG);
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_st <= NBMF_TX_IDLE;
            {tx_idx, tx_find, sent_id, sent_tmo, tx_busy_o, cfg_index_o} <= '0;
        end else begin
            tx_st <= next_tx_st;
            tx_idx <= next_tx_idx;
            tx_find <= next_tx_find;
            sent_id <= next_sent_id;
            sent_tmo <= next_sent_tmo;
            tx_busy_o <= next_tx_busy;
            cfg_index_o <= next_cfg_index;
        end
    end
    // ************************************************************
    // two-entry output buffer
    // ************************************************************
    // head plus skid entry keep every output a flop and lose nothing on a stall
    always_comb begin
        next_tx_beat = tx_beat_o;
        next_tx_valid = tx_valid_o;
        next_skid = skid;
        next_skid_v = skid_v;
        if (!tx_valid_o || tx_ready_i) begin
            if (skid_v) begin
                next_tx_beat = skid;
                next_tx_valid = 1'b1;
                next_skid_v = 1'b0;
            end else begin
                next_tx_beat = push_beat;
                next_tx_valid = push;
            end
        end else if (push) begin
            next_skid = push_beat;
            next_skid_v = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            {tx_beat_o, tx_valid_o, skid, skid_v} <= '0;
        end else begin
            tx_beat_o <= next_tx_beat;
            tx_valid_o <= next_tx_valid;
            skid <= next_skid;
            skid_v <= next_skid_v;
        end
    end
    // ************************************************************
    // receive checker and session tracking
    // ************************************************************
    // fields are checked as they pass; the verdict is taken on the last byte
    always_comb begin
        logic [9:0] m;
        logic hdr_ok, rpl_ok, last_ok;
        m = rx_idx - `NB_ETH_HDR;
        hdr_ok = 1'b0;
        rpl_ok = 1'b0;
        last_ok = 1'b0;
        next_sess_st = sess_st;
        next_session = session;
        next_server_known = server_known_o;
        next_server_addr = server_addr_o;
        next_server_timeout = server_timeout_o;
        next_find_reply = 1'b0;
        next_select_reply = 1'b0;
        next_rx_cmd_valid = 1'b0;
        next_rx_cmd_code = rx_cmd_code_o;
        next_rx_cmd_id = rx_cmd_id_o;
        next_rx_cmd_len = rx_cmd_len_o;
        next_rx_idx = rx_idx;
        next_drop = drop;
        next_src_mis = src_mis;
        next_id_mis = id_mis;
        next_sess_mis = sess_mis;
        next_cap_id = cap_id;
        next_cap_code = cap_code;
        next_cap_rpl = cap_rpl;
        next_cap_len = cap_len;
        next_cap_tmo = cap_tmo;
        next_cap_stn = cap_stn;
        next_cap_sess = cap_sess;
        if (start_find_ok) begin
            next_sess_st = NBMF_FIND; // a new discovery abandons any session, except one that a selection reply ending in the same cycle opens
            next_server_known = 1'b0;
        end else if (start_sel_ok) begin
            next_sess_st = NBMF_SEL;
        end
        if (rx_valid_i) begin
            if (rx_idx != `NB_RX_SAT) begin
                next_rx_idx = rx_idx + 10'h001;
            end
            if (rx_idx < `NB_MAC_LEN) begin
                next_drop = drop | (rx_data_i != nbmf_pick({80'h0, own_mac_i}, rx_idx[3:0]));
            end else if (rx_idx < `NB_SRC_END) begin
                next_src_mis = src_mis | (rx_data_i != nbmf_pick({80'h0, server_addr_o}, 4'(rx_idx - `NB_MAC_LEN)));
            end else if (rx_idx < `NB_ETH_HDR) begin
                next_drop = drop | (rx_data_i != nbmf_le(`NB_ETHTYPE, rx_idx == `NB_SRC_END));
            end else if (m < `NB_OFF_ID) begin
                next_drop = drop | (rx_data_i != nbmf_le(`NB_SUBTYPE, m[0]));
            end else if (m < `NB_OFF_REQ) begin
                next_id_mis = id_mis | (rx_data_i != nbmf_pick(sent_id, 4'(m - `NB_OFF_ID)));
                if (m < `NB_OFF_SESS_END) begin
                    next_sess_mis = sess_mis | (rx_data_i != nbmf_pick(session, 4'(m - `NB_OFF_ID)));
                end
                next_cap_id[{4'(m - `NB_OFF_ID), 3'b000} +: 8] = rx_data_i;
            end else if (m == `NB_OFF_REQ) begin
                next_cap_code = rx_data_i;
            end else if (m == `NB_OFF_RPL) begin
                next_cap_rpl = rx_data_i;
            end else if (m < `NB_OFF_VER) begin
                next_cap_len[{m[0], 3'b000} +: 8] = rx_data_i;
            end else if (m >= `NB_OFF_STN && m < `NB_OFF_SESS) begin
                next_cap_stn[{3'(m - `NB_OFF_STN), 3'b000} +: 8] = rx_data_i;
            end else if (m >= `NB_OFF_SESS && m < `NB_OFF_TMO) begin
                next_cap_sess[{4'(m - `NB_OFF_SESS), 3'b000} +: 8] = rx_data_i;
            end else if (m >= `NB_OFF_TMO && m < `NB_OFF_CFG) begin
                next_cap_tmo[{m[0], 3'b000} +: 8] = rx_data_i;
            end
            if (rx_last_i) begin
                hdr_ok = !next_drop && (rx_idx >= `NB_ETH_HDR + `NB_OFF_VER - 10'h001);
                last_ok = (rx_idx >= `NB_ETH_HDR + `NB_OFF_CFG - 10'h001);
                rpl_ok = hdr_ok && last_ok && (next_cap_rpl == 8'h00) && !next_id_mis
                    && (next_cap_len == `NB_RPL_LEN);
                if (rpl_ok && next_cap_code == `NB_CODE_FIND && sess_st == NBMF_FIND) begin
                    next_find_reply = 1'b1;
                    next_server_known = 1'b1;
                    next_server_addr = next_cap_stn;
                    next_server_timeout = next_cap_tmo;
                    next_sess_st = NBMF_IDLE;
                end else if (rpl_ok && next_cap_code == `NB_CODE_SEL && sess_st == NBMF_SEL
                    && !next_src_mis) begin
                    next_select_reply = 1'b1;
                    next_session = {32'h0, next_cap_sess};
                    next_server_timeout = next_cap_tmo;
                    next_sess_st = NBMF_OPEN;
                end else if (hdr_ok && sess_st == NBMF_OPEN && !next_src_mis && !next_sess_mis
                    && next_cap_code <= `NB_CODE_CMD_MAX) begin
                    next_rx_cmd_valid = 1'b1;
                    next_rx_cmd_code = next_cap_code;
                    next_rx_cmd_id = next_cap_id;
                    next_rx_cmd_len = next_cap_len;
                end
                // per-frame verdict flags start clean for the next frame
                next_rx_idx = 10'h000;
                next_drop = 1'b0;
                next_src_mis = 1'b0;
                next_id_mis = 1'b0;
                next_sess_mis = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sess_st <= NBMF_IDLE;
            {session, server_known_o, session_open_o, server_addr_o, server_timeout_o} <= '0;
            {find_reply_o, select_reply_o, rx_cmd_valid_o, rx_cmd_code_o, rx_cmd_id_o, rx_cmd_len_o} <= '0;
            {rx_idx, drop, src_mis, id_mis, sess_mis} <= '0;
            {cap_id, cap_code, cap_rpl, cap_len, cap_tmo, cap_stn, cap_sess} <= '0;
        end else begin
            sess_st <= next_sess_st;
            session <= next_session;
            server_known_o <= next_server_known;
            session_open_o <= (next_sess_st == NBMF_OPEN);
            server_addr_o <= next_server_addr;
            server_timeout_o <= next_server_timeout;
            find_reply_o <= next_find_reply;
            select_reply_o <= next_select_reply;
            rx_cmd_valid_o <= next_rx_cmd_valid;
            rx_cmd_code_o <= next_rx_cmd_code;
            rx_cmd_id_o <= next_rx_cmd_id;
            rx_cmd_len_o <= next_rx_cmd_len;
            rx_idx <= next_rx_idx;
            drop <= next_drop;
            src_mis <= next_src_mis;
            id_mis <= next_id_mis;
            sess_mis <= next_sess_mis;
            cap_id <= next_cap_id;
            cap_code <= next_cap_code;
            cap_rpl <= next_cap_rpl;
            cap_len <= next_cap_len;
            cap_tmo <= next_cap_tmo;
            cap_stn <= next_cap_stn;
            cap_sess <= next_cap_sess;
        end
    end
endmodule // nbmf_framer

// ==== nbmf_props.sv ====
// assertions on the boot message framer ports
// assumes it is bound into nbmf_framer, one clock domain
`timescale 1ns/1ps
module nbmf_props
    import nbmf_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic start_find_i,
    input wire logic start_select_i,
    input wire logic tx_busy_o,
    input nbmf_beat_s tx_beat_o,
    input wire logic tx_valid_o,
    input wire logic tx_ready_i,
    input wire logic rx_valid_i,
    input wire logic rx_last_i,
    input wire logic find_reply_o,
    input wire logic select_reply_o,
    input wire logic server_known_o,
    input wire logic session_open_o,
    input wire logic rx_cmd_valid_o
);
    // ****
    // frame and session checks
    // ****
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_go; start_find_i && !tx_busy_o; endsequence
    sequence s_bcast; tx_valid_o && tx_beat_o.data == 8'hFF; endsequence
    property p_dest; s_go |-> ##2 s_bcast; endproperty
    a_dest: assert property (p_dest) else $error("discovery not broadcast");
    property p_hold; tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_beat_o); endproperty
    a_hold: assert property (p_hold) else $error("beat moved while stalled");
    property p_busy; s_go |=> tx_busy_o [*8] ##[1:1000] !tx_busy_o; endproperty
    a_busy: assert property (p_busy) else $error("frame walk too short or hung");
    property p_find; find_reply_o |-> server_known_o && $past(rx_valid_i && rx_last_i); endproperty
    a_find: assert property (p_find) else $error("discovery reply pulse misplaced");
    property p_once; find_reply_o || select_reply_o |=> !find_reply_o && !select_reply_o; endproperty
    a_once: assert property (p_once) else $error("reply pulse too long");
    property p_sel; select_reply_o |-> session_open_o && server_known_o; endproperty
    a_sel: assert property (p_sel) else $error("session not open on selection reply");
    property p_refuse; start_select_i && !start_find_i && !server_known_o && !tx_busy_o |=> !tx_busy_o [*2];
    endproperty
    a_refuse: assert property (p_refuse) else $error("selection sent with no server");
    property p_cmd; rx_cmd_valid_o |-> session_open_o && $past(rx_last_i); endproperty
    a_cmd: assert property (p_cmd) else $error("command taken outside session");
endmodule // nbmf_props
bind nbmf_framer nbmf_props nbmf_props_i (.*);

// ==== nbmf_server.sv ====
// boot server model on the framer's tx and rx streams
// assumes one request at a time; replies 8 cycles after a frame
`timescale 1ns/1ps
module nbmf_server
    import nbmf_pkg::*;
#(
    parameter logic [47:0] SRV_MAC = 48'h0,
    parameter logic [95:0] SESS = 96'h0,
    parameter logic [15:0] SRV_TMO = 16'h0
)
(
    input wire logic clk_i,
    input wire logic [1:0] mode_i,
    input wire logic slow_i,
    input nbmf_beat_s tx_beat_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    output logic rx_last_o
);
    // ****
    // reply builder
    // ****
    logic [7:0] frm [0:141];
    int n;
    // mode 1 spoils the type, mode 2 the echoed id
    function automatic logic [7:0] rb(input int i, input logic [7:0] code);
        int m = i - 14;
        if (i < 6) return frm[6 + i];
        if (i < 12) return SRV_MAC[8*(i-6)+:8];
        if (i < 14) return (i == 12) ? {7'h3D, mode_i == 2'h1} : 8'h3C;
        if (m < 2 || m == 19 || m == 21 || m == 23 || m == 25) return 8'h00;
        if (m < 18 && code == 8'h02) return (m < 14) ? SESS[8*(m-2)+:8] : 8'hC3;
        if (m < 18) return frm[14 + m] ^ {7'h0, mode_i == 2'h2};
        if (m == 18) return code;
        if (m == 20) return (code == 8'h02) ? 8'h0E : 8'h1A;
        if (m < 28) return frm[14 + m];
        if (m < 34) return SRV_MAC[8*(m-28)+:8];
        if (m < 46) return SESS[8*(m-34)+:8];
        return (m == 46) ? SRV_TMO[7:0] : SRV_TMO[15:8];
    endfunction
    // released data shows the inverse so stale bytes never look valid
    task automatic send(input logic [7:0] code, input int len);
        for (int i = 0; i < len; i++) begin
            rx_data_o <= rb(i, code);
            rx_valid_o <= 1'b1;
            rx_last_o <= (i == len - 1);
            @(posedge clk_i);
        end
        rx_valid_o <= 1'b0;
        rx_last_o <= 1'b0;
        rx_data_o <= ~rx_data_o;
    endtask
    // stall pattern: ready every other cycle when slow
    always @(posedge clk_i) tx_ready_o <= slow_i ? ~tx_ready_o : 1'b1;
    // capture a request, answer it, open with a command after selection
    initial begin
        n = 0;
        rx_valid_o = 1'b0;
        rx_last_o = 1'b0;
        rx_data_o = 8'hA5;
        forever begin
            @(posedge clk_i);
            if (tx_valid_i && tx_ready_o) begin
                frm[n] = tx_beat_i.data;
                n = tx_beat_i.last ? 0 : n + 1;
                if (tx_beat_i.last) begin
                    repeat (8) @(posedge clk_i);
                    send(frm[32], 62);
                    if (frm[32] == 8'h05 && mode_i == 2'h0) begin
                        repeat (4) @(posedge clk_i);
                        send(8'h02, 36);
                    end
                end
            end
        end
    end
endmodule // nbmf_server

// ==== tb.sv ====
// self-checking bench for the boot message framer
// assumes nbmf_server answers on the rx stream
`timescale 1ns/1ps
module tb
    import nbmf_pkg::*;
;
    // ****
    // bench
    // ****
    localparam logic [47:0] SRV = 48'h0E0D0C0B0A02;
    localparam logic [95:0] SESS = 96'h0123456789ABCDEF13579BDF;
    localparam logic [15:0] STMO = 16'h0BB8;
    logic clk_i, reset_n_i, start_find_i, start_select_i, tx_busy_o, tx_valid_o, tx_ready_i, slow;
    logic rx_valid_i, rx_last_i, find_reply_o, select_reply_o, server_known_o, session_open_o, rx_cmd_valid_o;
    logic [47:0] own_mac_i, server_addr_o;
    logic [127:0] msg_id_i, rx_cmd_id_o;
    logic [15:0] rx_timeout_i, server_timeout_o, rx_cmd_len_o, lf;
    logic [7:0] cfg_byte_i, rx_data_i, rx_cmd_code_o;
    logic [6:0] cfg_index_o;
    logic [1:0] mode;
    nbmf_beat_s tx_beat_o;
    int error_cnt, num_checks, cyc;
    // config lookup answers in the same cycle
    assign cfg_byte_i = {1'b0, cfg_index_o} ^ 8'h5A;
    nbmf_framer nbmf_framer_i (.*);
    nbmf_server #(.SRV_MAC(SRV), .SESS(SESS), .SRV_TMO(STMO)) nbmf_server_i (.clk_i(clk_i), .mode_i(mode),
        .slow_i(slow), .tx_beat_i(tx_beat_o), .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i),
        .rx_data_o(rx_data_i), .rx_valid_o(rx_valid_i), .rx_last_o(rx_last_i));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    function automatic logic [15:0] step(input logic [15:0] s);
        return {1'b0, s[15:1]} ^ (s[0] ? 16'hB400 : 16'h0000);
    endfunction
    // expected request byte; bit 8 clear where the field is undefined
    function automatic logic [8:0] exp_b(input int i, input logic [7:0] code, input logic [47:0] dst);
        int m = i - 14;
        if (i < 6) return {1'b1, dst[8*i+:8]};
        if (i < 12) return {1'b1, own_mac_i[8*(i-6)+:8]};
        if (i < 14) return {1'b1, (i == 12) ? 8'h7A : 8'h3C};
        if (m >= 2 && m < 18) return {1'b1, msg_id_i[8*(m-2)+:8]};
        if (m == 18) return {1'b1, code};
        if (m == 20) return 9'h16A;
        if (m == 22 || m == 24 || m == 27) return 9'h101;
        if (m == 26) return 9'h1FC;
        if (m >= 28 && m < 34) return {1'b1, own_mac_i[8*(m-28)+:8]};
        if (m >= 34 && m < 46) return 9'h000;
        if (m == 46 || m == 47) return {1'b1, rx_timeout_i[8*(m-46)+:8]};
        if (m >= 48) return {1'b1, 8'(m - 48) ^ 8'h5A};
        return 9'h100;
    endfunction
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // one request with fresh random id, frame compare, reply watch
    task automatic req(input logic [7:0] code, input logic [1:0] md, input logic [47:0] dst);
        logic [8:0] e;
        logic got;
        for (int k = 0; k < 8; k++) begin
            lf = step(lf);
            msg_id_i[16*k+:16] <= lf;
        end
        rx_timeout_i <= lf ^ 16'h3C3C;
        mode <= md;
        slow <= md[0] | lf[0];
        start_find_i <= (code == 8'h04);
        start_select_i <= (code == 8'h05);
        @(posedge clk_i);
        start_find_i <= 1'b0;
        start_select_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        for (int t = 0; t < 2000 && (tx_busy_o || tx_valid_o); t++) @(posedge clk_i);
        for (int i = 0; i < 142; i++) begin
            e = exp_b(i, code, dst);
            if (e[8]) check(nbmf_server_i.frm[i], e[7:0]);
        end
        got = 1'b0;
        for (int t = 0; t < 200; t++) begin
            @(posedge clk_i);
            got = got | ((code == 8'h04) ? find_reply_o : select_reply_o);
        end
        check(got, md == 2'h0);
    endtask
    // cut a hang short
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end
    initial begin
        {error_cnt, num_checks, mode, slow} = '0;
        {reset_n_i, start_find_i, start_select_i, msg_id_i, rx_timeout_i} = '0;
        lf = 16'hA428;
        own_mac_i = 48'h0000_0000_0000;
        repeat (8) @(posedge clk_i);
        reset_n_i <= 1'b1;
        own_mac_i <= {16'h0A02, 16'hC0DE, step(lf)};
        start_select_i <= 1'b1;
        @(posedge clk_i);
        start_select_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        check(tx_busy_o, 1'b0);
        req(8'h04, 2'h1, 48'hFFFF_FFFF_FFFF);
        check(server_known_o, 1'b0);
        req(8'h04, 2'h2, 48'hFFFF_FFFF_FFFF);
        check(server_known_o, 1'b0);
        for (int r = 0; r < 3; r++) begin
            req(8'h04, 2'h0, 48'hFFFF_FFFF_FFFF);
            check(server_addr_o, SRV);
            check(server_timeout_o, STMO);
            req(8'h05, 2'h0, SRV);
            check(session_open_o, 1'b1);
            check(rx_cmd_id_o[95:0], SESS);
            check(rx_cmd_code_o, 8'h02);
            check(rx_cmd_len_o, 16'h000E);
        end
        summarize();
    end
endmodule // tb
